/* rtl/rmb_bridge.sv */
// Summary of operation
// R1: tunneling selected: frames to buffer, not EEPROM
// R2: tunneling errors raise CRC, parity, framing flags
// R3: host commands send ACK or NAK 0-5
// R4: transmit command sends buffer contents over RF
// R5: host commands move tag to sleep/sense
// R6: host EEPROM access unaffected by tunneling
// R7: both modes enabled means tunneling wins
// R8: extended blocks FCh-FFh reach mailbox buffer
// R9: extended frames with errors are silently dropped
// R10: good extended mailbox write answered with ACK
// R11: buffer granted to one side at once
// R12: buffer kept, cleared when field returns
// R13: reader writes FCh, FDh, FEh, then FFh
// R14: FCh write sets busy, rx start, blocks host
// R15: FFh write raises rx end, sets ready
// R16: FFh before FCh answered with error
// R17: ready flag freezes buffer to reader writes, which get error; host byte writes still land
// R18: block FCh-FFh stored at offsets 0,4,8,C
// R19: host reads bytes in order from 00h
// R20: clear command drops ready, accepts new message
// R21: transmit command sets host data ready
// R22: FCh read returns status in fourth word
// R23: early FCh read returns zeros, busy status
// R24: reader FFh write releases buffer, tx end
`timescale 1ns/1ps
`default_nettype none
module rmb_bridge import rmb_pkg::*; (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// mode bits of mode_config_byte
	input wire logic tun_mod_i,
	input wire logic ext_mod_i,
	// tag state from the RF front end
	input wire logic selected_i,
	input wire logic field_present_i,
	// received RF frame, held until taken
	input wire logic rf_frame_i,
	input wire rmb_rfcmd_type rf_cmd_i,
	input wire logic [7:0] rf_addr_i,
	input wire logic [31:0] rf_data_i,
	input wire logic [BUF_BITS-1:0] rf_raw_i,
	input wire logic [4:0] rf_len_i,
	input wire logic rf_crc_err_i,
	input wire logic rf_par_err_i,
	input wire logic rf_frm_err_i,
	output logic rf_ready_o,
	output logic rf_to_eeprom_o,
	// response toward the RF transmitter
	output logic resp_valid_o,
	input wire logic resp_ready_i,
	output logic [1:0] resp_kind_o,
	output logic [2:0] resp_nak_o,
	output logic [BUF_BITS-1:0] resp_data_o,
	// host direct commands, held until done
	input wire logic host_cmd_valid_i,
	input wire rmb_hcmd_type host_cmd_i,
	input wire logic [2:0] host_nak_i,
	output logic host_cmd_done_o,
	// host buffer byte access
	input wire logic host_buf_wr_i,
	input wire logic host_buf_rd_i,
	input wire logic [7:0] host_wr_byte_i,
	output logic [7:0] host_rd_byte_o,
	output logic host_rd_valid_o,
	// status flags
	output logic reader_write_in_progress_o,
	output logic reader_message_ready_o,
	output logic host_data_ready_o,
	output logic [4:0] buf_len_o,
	// event pulses
	output logic rx_start_o,
	output logic rx_end_o,
	output logic tx_end_o,
	output logic crc_err_o,
	output logic par_err_o,
	output logic frm_err_o,
	output logic buffer_fault_irq_o,
	output logic acc_err_o,
	output logic goto_sleep_o,
	output logic goto_sense_o
);
	logic [7:0] mem [BUF_BYTES];
	logic [7:0] next_mem [BUF_BYTES];
	logic [3:0] ptr, next_ptr;
	logic field_s1, field_s2, field_d;
	logic busy, msg_rdy, host_rdy, next_busy, next_msg_rdy, next_host_rdy;
	logic [4:0] len, next_len;
	logic [7:0] rd_byte, next_rd_byte;
	logic [13:0] ev, next_ev;
	logic tun, ext, field_rise, frame_acc, cmd_acc, push, win, any_err;
	logic [1:0] push_kind;
	logic [2:0] push_nak;
	logic [BUF_BITS-1:0] push_data, buf_flat;
	rmb_stream_if #(.W(RSP_W)) rsp ();

	// big-endian word of the mailbox
	function automatic logic [31:0] buf_word(input logic [7:0] m [BUF_BYTES], input int w);
		buf_word = {m[4*w], m[4*w+1], m[4*w+2], m[4*w+3]};
	endfunction

	// byte offset of a block in the window
	function automatic logic [3:0] blk_ofs(input logic [7:0] a);
		blk_ofs = {a[1:0], 2'b00};
	endfunction

	assign tun = tun_mod_i; // R7
	assign ext = ext_mod_i && !tun_mod_i; // R7
	assign field_rise = field_s2 && !field_d;
	// field glitch of no RF means power side keeps us alive; only a return wipes state
	assign frame_acc = rf_frame_i && rsp.push_ready && !field_rise;
	// RF wins the cycle; host commands wait, so the buffer never sees two masters
	assign cmd_acc = host_cmd_valid_i && rsp.push_ready && !rf_frame_i && !field_rise; // R11
	assign win = rf_addr_i >= ADDR_FIRST;
	assign any_err = rf_crc_err_i || rf_par_err_i || rf_frm_err_i;
	assign buf_flat = {buf_word(mem, 0), buf_word(mem, 1), buf_word(mem, 2), buf_word(mem, 3)};

	// field pin synchroniser
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			field_s1 <= 1'b0;
			field_s2 <= 1'b0;
			field_d <= 1'b0;
		end else begin
			field_s1 <= field_present_i;
			field_s2 <= field_s1;
			field_d <= field_s2;
		end
	end

	// ev bits 13..0: rx_start rx_end tx_end crc par frm bf acc sleep sense spare done eeprom rdv
	always_comb begin
		next_mem = mem;
		next_ptr = ptr;
		next_busy = busy;
		next_msg_rdy = msg_rdy;
		next_host_rdy = host_rdy;
		next_len = len;
		next_rd_byte = rd_byte;
		next_ev = '0;
		push = 1'b0;
		push_kind = RSP_ACK;
		push_nak = '0;
		push_data = '0;
		if (field_rise) begin
			for (int i = 0; i < BUF_BYTES; i++) next_mem[i] = '0; // R12
			next_busy = 1'b0;
			next_msg_rdy = 1'b0;
			next_host_rdy = 1'b0;
			next_ptr = '0;
			next_len = '0;
		end else if (frame_acc && selected_i && tun) begin
			// whole frame goes to the host unless a message is still ready (buffer fault); EEPROM path stays closed
			next_ev[13:12] = 2'b11; // R1
			next_ev[10] = rf_crc_err_i; // R2
			next_ev[9] = rf_par_err_i; // R2
			next_ev[8] = rf_frm_err_i; // R2
			if (msg_rdy) begin
				next_ev[7] = 1'b1;
			end else begin
				for (int i = 0; i < BUF_BYTES; i++) next_mem[i] = rf_raw_i[BUF_BITS-1-8*i -: 8]; // R1
				next_len = rf_len_i;
				next_msg_rdy = 1'b1;
			end
		end else if (frame_acc && selected_i && ext && win) begin
			if (any_err) begin
				push = 1'b0; // R9
			end else if (rf_cmd_i == RF_WRITE) begin
				push = 1'b1;
				if (host_rdy && rf_addr_i == ADDR_LAST) begin
					for (int i = 0; i < BUF_BYTES; i++) next_mem[i] = '0; // R24
					next_host_rdy = 1'b0; // R24
					next_ev[11] = 1'b1; // R24
				end else if (msg_rdy || host_rdy || (rf_addr_i != ADDR_FIRST && !busy)) begin
					push_kind = RSP_NAK; // R16 R17
					push_nak = EXT_ERR_NAK;
				end else begin
					for (int b = 0; b < 4; b++) next_mem[blk_ofs(rf_addr_i) + 4'(b)] = rf_data_i[31-8*b -: 8]; // R8 R18
					if (rf_addr_i == ADDR_FIRST) begin
						next_busy = 1'b1; // R14
						next_ev[13] = 1'b1; // R14
					end
					if (rf_addr_i == ADDR_LAST) begin
						next_busy = 1'b0;
						next_msg_rdy = 1'b1; // R15
						next_ev[12] = 1'b1; // R15
						next_len = BUF_LEN_FULL;
					end
				end // ack stays the default kind: R10
			end else if (rf_cmd_i == RF_READ && rf_addr_i == ADDR_FIRST) begin
				push = 1'b1;
				push_kind = RSP_DATA;
				if (host_rdy) begin
					push_data = {buf_word(mem, 0), buf_word(mem, 1), buf_word(mem, 2), STAT_PAD, STAT_READY}; // R22
				end else begin
					push_data = {96'h0000_0000_0000_0000_0000_0000, STAT_PAD, STAT_BUSY}; // R23
				end
			end else begin
				push = 1'b1;
				push_kind = RSP_NAK;
				push_nak = EXT_ERR_NAK;
			end
		end else if (frame_acc) begin
			next_ev[1] = 1'b1; // R8
		end else if (cmd_acc) begin
			next_ev[2] = 1'b1;
			unique case (host_cmd_i)
				HC_TX_ACK: begin
					push = 1'b1; // R3
				end
				HC_TX_NAK: begin
					push = 1'b1;
					push_kind = RSP_NAK;
					push_nak = (host_nak_i > NAK_MAX) ? NAK_MAX : host_nak_i; // R3
				end
				HC_TX_BUF: begin
					if (tun) begin
						push = 1'b1;
						push_kind = RSP_DATA;
						push_data = buf_flat; // R4
					end else begin
						next_host_rdy = 1'b1; // R21
					end
				end
				HC_CLEAR: begin
					if (busy) begin
						next_ev[6] = 1'b1;
					end else begin
						for (int i = 0; i < BUF_BYTES; i++) next_mem[i] = '0;
						next_msg_rdy = 1'b0; // R20
						next_ptr = '0;
						next_len = '0;
					end
				end
				HC_SLEEP: next_ev[5] = 1'b1; // R5
				HC_SENSE, HC_SENSE_SLEEP: next_ev[4] = 1'b1; // R5
				HC_NONE: next_ev[2] = 1'b1;
			endcase
		end
		// host byte port; refused while reader owns the buffer, and writes also while data awaits release
		if ((host_buf_wr_i || host_buf_rd_i) && !field_rise) begin
			if (busy || frame_acc || (host_buf_wr_i && host_rdy)) begin
				next_ev[6] = 1'b1; // R11 R14
			end else if (host_buf_wr_i) begin
				next_mem[ptr] = host_wr_byte_i;
				next_ptr = ptr + 4'h1;
			end else begin
				next_rd_byte = mem[ptr]; // R19
				next_ev[0] = 1'b1;
				next_ptr = ptr + 4'h1;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < BUF_BYTES; i++) mem[i] <= '0;
			ptr <= '0;
			busy <= 1'b0;
			msg_rdy <= 1'b0;
			host_rdy <= 1'b0;
			len <= '0;
			rd_byte <= '0;
			ev <= '0;
		end else begin
			mem <= next_mem;
			ptr <= next_ptr;
			busy <= next_busy;
			msg_rdy <= next_msg_rdy;
			host_rdy <= next_host_rdy;
			len <= next_len;
			rd_byte <= next_rd_byte;
			ev <= next_ev;
		end
	end

	// response path; a stalled transmitter back-pressures both RF and host
	assign rsp.push_valid = push;
	assign rsp.push_data = {push_kind, push_nak, push_data};
	assign rsp.pop_ready = resp_ready_i;
	rmb_pair_buf #(.W(RSP_W)) u_rsp_buf (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.st(rsp.buffer)
	);

	assign rf_ready_o = rsp.push_ready;
	assign resp_valid_o = rsp.pop_valid;
	assign resp_kind_o = rsp.pop_data[RSP_W-1 -: 2];
	assign resp_nak_o = rsp.pop_data[BUF_BITS+2 -: 3];
	assign resp_data_o = rsp.pop_data[BUF_BITS-1:0];
	// host EEPROM port lives outside and is never gated here
	assign rf_to_eeprom_o = ev[1]; // R6
	assign host_cmd_done_o = ev[2];
	assign host_rd_byte_o = rd_byte;
	assign host_rd_valid_o = ev[0];
	assign reader_write_in_progress_o = busy;
	assign reader_message_ready_o = msg_rdy;
	assign host_data_ready_o = host_rdy;
	assign buf_len_o = len;
	assign rx_start_o = ev[13];
	assign rx_end_o = ev[12];
	assign tx_end_o = ev[11];
	assign crc_err_o = ev[10];
	assign par_err_o = ev[9];
	assign frm_err_o = ev[8];
	assign buffer_fault_irq_o = ev[7];
	assign acc_err_o = ev[6];
	assign goto_sleep_o = ev[5];
	assign goto_sense_o = ev[4];

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_ext_first;
		frame_acc && selected_i && ext && rf_cmd_i == RF_WRITE && rf_addr_i == ADDR_FIRST && !any_err
			&& !msg_rdy && !host_rdy;
	endsequence
	a_tun_no_eeprom: assert property (frame_acc && selected_i && tun |=> !rf_to_eeprom_o && rx_end_o) // R1
		else $error("tunneled frame leaked to eeprom");
	a_tun_crc_flag: assert property (frame_acc && selected_i && tun && rf_crc_err_i |=> crc_err_o) // R2
		else $error("crc flag missing");
	a_nak_range: assert property (push && push_kind == RSP_NAK |-> push_nak <= NAK_MAX) // R3
		else $error("nak code out of range");
	a_mode_prio: assert property (tun_mod_i |-> !ext) // R7
		else $error("extended active with tunneling");
	a_ext_drop: assert property (frame_acc && selected_i && ext && win && any_err |-> !push) // R9
		else $error("errored frame answered");
	a_first_store: assert property (s_ext_first |=> busy && rx_start_o && mem[0] == $past(rf_data_i[31:24])) // R14
		else $error("first block not taken");
	a_busy_refuse: assert property (busy && host_buf_wr_i && !field_rise |=> acc_err_o) // R14
		else $error("host not refused while busy");
	a_ready_hold: assert property (msg_rdy && !field_rise && !(cmd_acc && host_cmd_i == HC_CLEAR)
		&& !host_buf_wr_i |=> $stable(buf_flat)) // R17
		else $error("buffer changed while ready");
	a_field_clear: assert property (field_rise |=> buf_flat == '0 && !msg_rdy ##1 !reader_message_ready_o) // R12
		else $error("field return kept buffer");
endmodule
`default_nettype wire

/* rtl/rmb_pair_buf.sv */
`timescale 1ns/1ps
`default_nettype none
module rmb_pair_buf #(parameter int W = 8) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// both sides of the buffer
	rmb_stream_if.buffer st
);
	logic [W-1:0] head, tail, next_head, next_tail;
	logic head_v, tail_v, not_full, next_head_v, next_tail_v, next_not_full;

	// shift-style pair: head always feeds the output so pop data is a flop
	always_comb begin
		next_head = head;
		next_tail = tail;
		next_head_v = head_v;
		next_tail_v = tail_v;
		if (head_v && st.pop_ready) begin
			if (tail_v) begin
				next_head = tail;
				next_tail_v = 1'b0;
			end else begin
				next_head_v = 1'b0;
			end
		end
		if (st.push_valid && not_full) begin
			if (!next_head_v) begin
				next_head = st.push_data;
				next_head_v = 1'b1;
			end else begin
				next_tail = st.push_data;
				next_tail_v = 1'b1;
			end
		end
		next_not_full = !next_tail_v;
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			head <= '0;
			tail <= '0;
			head_v <= 1'b0;
			tail_v <= 1'b0;
			not_full <= 1'b1;
		end else begin
			head <= next_head;
			tail <= next_tail;
			head_v <= next_head_v;
			tail_v <= next_tail_v;
			not_full <= next_not_full;
		end
	end

	assign st.push_ready = not_full;
	assign st.pop_valid = head_v;
	assign st.pop_data = head;
endmodule
`default_nettype wire

/* rtl/rmb_pkg.sv */
package rmb_pkg;
	// mailbox geometry
	localparam int BUF_BYTES = 16;
	localparam int BUF_BITS = BUF_BYTES * 8;
	localparam logic [4:0] BUF_LEN_FULL = 5'h10;
	// extended-mode block window
	localparam logic [7:0] ADDR_FIRST = 8'hFC;
	localparam logic [7:0] ADDR_LAST = 8'hFF;
	// negative acknowledge codes
	localparam logic [2:0] NAK_MAX = 3'h5;
	localparam logic [2:0] EXT_ERR_NAK = 3'h1;
	// status byte returned in the fourth word of a block read
	localparam logic [7:0] STAT_READY = 8'h01;
	localparam logic [7:0] STAT_BUSY = 8'h02;
	localparam logic [23:0] STAT_PAD = 24'h00_0000;

	typedef enum logic [1:0] {RF_OTHER, RF_READ, RF_WRITE} rmb_rfcmd_type;
	typedef enum logic [2:0] {HC_NONE, HC_TX_ACK, HC_TX_NAK, HC_TX_BUF, HC_CLEAR, HC_SLEEP, HC_SENSE,
		HC_SENSE_SLEEP} rmb_hcmd_type;
	typedef enum logic [1:0] {RSP_ACK, RSP_NAK, RSP_DATA} rmb_rspkind_type;

	// response word: kind, nak code, payload
	localparam int RSP_W = 2 + 3 + BUF_BITS;
endpackage

/* rtl/rmb_stream_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface rmb_stream_if #(parameter int W = 8);
	logic push_valid;
	logic push_ready;
	logic [W-1:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [W-1:0] pop_data;
	modport producer (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
	modport buffer (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

/* testbench/rmb_rf_tx_model.sv */
`timescale 1ns/1ps
`default_nettype none
// reader-side transmitter: takes response words, can stall
module rmb_rf_tx_model import rmb_pkg::*; (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// response stream from the bridge
	input wire logic resp_valid_i,
	input wire logic [1:0] resp_kind_i,
	input wire logic [2:0] resp_nak_i,
	input wire logic [BUF_BITS-1:0] resp_data_i,
	input wire logic stall_i,
	output logic resp_ready_o,
	// last word taken and running count
	output logic [1:0] kind_o,
	output logic [2:0] nak_o,
	output logic [BUF_BITS-1:0] data_o,
	output logic [7:0] cnt_o
);
	// ready is registered so it only moves just after an edge
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			resp_ready_o <= 1'b0;
			cnt_o <= 8'h00;
		end else begin
			resp_ready_o <= ~stall_i;
			if (resp_valid_i && resp_ready_o) begin
				kind_o <= resp_kind_i;
				nak_o <= resp_nak_i;
				data_o <= resp_data_i;
				cnt_o <= cnt_o + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

/* testbench/tb_rmb_bridge.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_rmb_bridge import rmb_pkg::*;;
	logic mclk = 0, reset_n = 0, tun = 0, ext = 1, sel = 1, field = 1, frame = 0, stall = 0;
	rmb_rfcmd_type cmd = RF_OTHER;
	logic [7:0] addr = 0, hwb = 0, pc, c0;
	logic [31:0] wdata = 0;
	logic [2:0] err = 0, hn = 0, pn, rn;
	logic rf_rdy, to_ee, rv, rr, hdone, hrv, busy, mrdy, hdr;
	logic hv = 0, hwr = 0, hrd = 0;
	rmb_hcmd_type hc = HC_NONE;
	logic [1:0] rk, pk;
	logic [7:0] hrb;
	logic [4:0] blen;
	logic [127:0] rd, pd, q;
	wire logic [9:0] ev;
	int cnt[10], cnt_ee = 0, cnt_rv = 0, fails = 0, tests_run = 0, cyc = 0;

	rmb_bridge u_rmb_bridge (.mclk_i(mclk), .reset_n_i(reset_n), .tun_mod_i(tun), .ext_mod_i(ext),
		.selected_i(sel), .field_present_i(field), .rf_frame_i(frame), .rf_cmd_i(cmd), .rf_addr_i(addr),
		.rf_data_i(wdata), .rf_raw_i({4{wdata}}), .rf_len_i(5'h04), .rf_crc_err_i(err[0]),
		.rf_par_err_i(err[1]), .rf_frm_err_i(err[2]), .rf_ready_o(rf_rdy), .rf_to_eeprom_o(to_ee),
		.resp_valid_o(rv), .resp_ready_i(rr), .resp_kind_o(rk), .resp_nak_o(rn), .resp_data_o(rd),
		.host_cmd_valid_i(hv), .host_cmd_i(hc), .host_nak_i(hn), .host_cmd_done_o(hdone),
		.host_buf_wr_i(hwr), .host_buf_rd_i(hrd), .host_wr_byte_i(hwb), .host_rd_byte_o(hrb),
		.host_rd_valid_o(hrv), .reader_write_in_progress_o(busy), .reader_message_ready_o(mrdy),
		.host_data_ready_o(hdr), .buf_len_o(blen), .rx_start_o(ev[0]), .rx_end_o(ev[1]),
		.tx_end_o(ev[2]), .crc_err_o(ev[3]), .par_err_o(ev[4]), .frm_err_o(ev[5]),
		.buffer_fault_irq_o(ev[6]), .acc_err_o(ev[7]), .goto_sleep_o(ev[8]), .goto_sense_o(ev[9]));
	rmb_rf_tx_model u_rmb_rf_tx_model (.mclk_i(mclk), .reset_n_i(reset_n), .resp_valid_i(rv),
		.resp_kind_i(rk), .resp_nak_i(rn), .resp_data_i(rd), .stall_i(stall),
		.resp_ready_o(rr), .kind_o(pk), .nak_o(pn), .data_o(pd), .cnt_o(pc));

	// clock, event tally and hang guard
	initial forever #2.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		cnt_ee += (to_ee === 1'b1);
		cnt_rv += (hrv === 1'b1);
		for (int i = 0; i < 10; i++) cnt[i] += (ev[i] === 1'b1);
		if (cyc == 20000) begin
			fails++;
			conclude();
		end
	end

	task conclude;
		if (fails == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input logic [127:0] got, input logic [127:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one reader frame; waits a bounded time for a response word
	task rf(input rmb_rfcmd_type c, input logic [7:0] a, input logic [31:0] d, input logic [2:0] e);
		int n;
		@(negedge mclk);
		c0 = pc;
		cmd = c;
		addr = a;
		wdata = d;
		err = e;
		frame = 1;
		for (n = 0; rf_rdy !== 1'b1 && n < 50; n++) @(negedge mclk);
		@(negedge mclk);
		frame = 0;
		for (n = 0; pc === c0 && n < 12; n++) @(negedge mclk);
	endtask

	// direct command, held until done is seen
	task hcmd(input rmb_hcmd_type c, input logic [2:0] k);
		int n;
		@(negedge mclk);
		hc = c;
		hn = k;
		hv = 1;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (hdone !== 1'b1 && n < 50);
		hv = 0;
		repeat (3) @(negedge mclk);
	endtask

	// sixteen back-to-back byte strobes, reads gathered into q
	task hbytes(input logic wr, input logic [127:0] d);
		for (int i = 0; i <= 16; i++) begin
			@(negedge mclk);
			if (i > 0) q[135-8*i -: 8] = hrb;
			hrd = !wr && i < 16;
			hwr = wr && i < 16;
			if (i < 16) hwb = d[127-8*i -: 8];
		end
		// let the pulse of the last strobe reach the tally
		@(negedge mclk);
	endtask

	initial begin
		for (int i = 0; i < 10; i++) cnt[i] = 0;
		repeat (10) @(posedge mclk);
		@(negedge mclk) reset_n = 1;
		repeat (4) @(negedge mclk);
		// extended mode, reader side first
		rf(RF_READ, ADDR_FIRST, 0, 0); chk(pd, {120'h0, STAT_BUSY});
		rf(RF_WRITE, ADDR_LAST, 0, 0); chk({pk, pn}, {RSP_NAK, EXT_ERR_NAK});
		rf(RF_WRITE, ADDR_FIRST, 32'h1234_5678, 3'h1); chk(pc, c0);
		rf(RF_WRITE, ADDR_FIRST, 32'h0011_2233, 0); chk(pk, RSP_ACK);
		chk({busy, cnt[0]}, {1'b1, 32'h1});
		hbytes(0, 0); chk(cnt[7], 16);
		rf(RF_WRITE, 8'hFD, 32'h4455_6677, 0);
		stall = 1; // receiver holds off one response
		rf(RF_WRITE, 8'hFE, 32'h8899_AABB, 0); chk(pc, c0);
		stall = 0;
		repeat (4) @(negedge mclk);
		chk({pk, pc}, {RSP_ACK, c0 + 8'h01});
		rf(RF_WRITE, ADDR_LAST, 32'hCCDD_EEFF, 0);
		chk({cnt[1], mrdy, busy, blen}, {32'h1, 1'b1, 1'b0, BUF_LEN_FULL});
		rf(RF_WRITE, ADDR_FIRST, 0, 0); chk({pk, pn}, {RSP_NAK, EXT_ERR_NAK});
		hbytes(0, 0); chk(q, 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF);
		chk(cnt_rv, 16);
		hcmd(HC_CLEAR, 0); chk(mrdy, 0);
		// host to reader direction
		hbytes(1, {96'h1020_3040_5060_7080_90A0_B0C0, 32'h0});
		hcmd(HC_TX_BUF, 0); chk(hdr, 1);
		rf(RF_READ, ADDR_FIRST, 0, 0); chk(pd, {96'h1020_3040_5060_7080_90A0_B0C0, 24'h0, STAT_READY});
		rf(RF_WRITE, ADDR_LAST, 0, 0); chk({cnt[2], pk}, {32'h1, RSP_ACK});
		rf(RF_WRITE, 8'h10, 0, 0); chk(cnt_ee, 1);
		// field drops and returns mid-message
		rf(RF_WRITE, ADDR_FIRST, 32'h5555_5555, 0);
		@(negedge mclk) field = 0;
		repeat (5) @(negedge mclk);
		field = 1;
		repeat (6) @(negedge mclk);
		chk({busy, blen}, 0);
		hbytes(0, 0); chk(q, 128'h0);
		// tunneling wins with both bits set
		tun = 1;
		for (int k = 0; k < 3; k++) begin
			rf(RF_OTHER, 0, 0, 3'h1 << k); chk(cnt[3+k], 1);
		end
		rf(RF_WRITE, 8'h10, 32'hA5A5_A5A5, 0); chk(cnt_ee, 1);
		chk(cnt[6], 3);
		for (int k = 0; k < 6; k++) begin
			hcmd(HC_TX_NAK, k[2:0]); chk({pk, pn}, {RSP_NAK, k[2:0]});
		end
		hcmd(HC_TX_ACK, 0); chk(pk, RSP_ACK);
		hbytes(1, 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210);
		hcmd(HC_TX_BUF, 0); chk({pk, pd}, {RSP_DATA, 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210});
		hcmd(HC_SLEEP, 0); chk(cnt[8], 1);
		hcmd(HC_SENSE, 0); chk(cnt[9], 1);
		hcmd(HC_SENSE_SLEEP, 0); chk(cnt[9], 2);
		conclude();
	end
endmodule
`default_nettype wire
